// [rtl/cswd_top.sv]
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "cswd_regs.svh"
module cswd_top #(
  parameter int SILENCE_CYC = `CSWD_SILENCE_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cswd_pkg::cswd_dev_mode_t dev_mode,
  input wire logic rx_normal,
  input wire logic rx_low_power,
  input wire logic bus_transmit_pin,
  input wire logic pattern_wake_in,
  input wire logic frame_match_in,
  output logic [2:0] trx_mode_out,
  output logic selective_wake_out,
  output logic wake_restart,
  output logic wake_irq,
  output logic [7:0] osc_trim_out
);
  import cswd_pkg::*;

  // ==========================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // ==========================================
  // register bus
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_go;
  logic [2:0] trx_mode_ff;
  logic [4:0] wake_flags_ff;
  logic [5:0] error_count_field_ff;
  logic [7:0] tq_ff;
  logic [5:0] sp_ff;
  logic rcv_en_ff;
  logic [1:0] osc_sel_ff;
  logic rx_sel_ff;
  logic [9:0] lim_lo_ff;
  logic [9:0] lim_hi_ff;
  logic fd_en_ff;
  logic error_count_field_dis_ff;
  logic [3:0] flt_ff;
  logic cal_ff;
  logic [1:0] trim_en_ff;
  logic [15:0] cal_cnt_ff;
  logic [15:0] cal_res_ff;
  logic [7:0] trim_ff;
  logic [9:0] cur_len_ff;
  logic [31:0] wv;

  // one wait cycle per access: answer lands on the second edge of the request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(wait_ff && (avs_read || avs_write));
    end
  end
  assign wr_go = avs_write && !wait_ff;

  always_comb begin
    nxt_rdata = 32'h0;
    case (avs_address)
      `CSWD_ADR_MODE: nxt_rdata[2:0] = trx_mode_ff; // R24
      `CSWD_ADR_WAKE: nxt_rdata = {21'h0, error_count_field_ff, wake_flags_ff}; // R3
      `CSWD_ADR_TIMING: nxt_rdata = {18'h0, sp_ff, tq_ff}; // R4
      `CSWD_ADR_RCV_CTRL: nxt_rdata[3:0] = {rx_sel_ff, osc_sel_ff, rcv_en_ff};
      `CSWD_ADR_RCV_LIM: nxt_rdata = {6'h0, lim_hi_ff, 6'h0, lim_lo_ff};
      `CSWD_ADR_FAST: nxt_rdata[5:0] = {flt_ff, error_count_field_dis_ff, fd_en_ff};
      `CSWD_ADR_CAL: nxt_rdata[2:0] = {trim_en_ff, cal_ff};
      `CSWD_ADR_CAL_HI: nxt_rdata[7:0] = cal_res_ff[15:8]; // R6
      `CSWD_ADR_CAL_LO: nxt_rdata[7:0] = cal_res_ff[7:0]; // R6
      `CSWD_ADR_TRIM: nxt_rdata[7:0] = trim_ff;
      `CSWD_ADR_RCV_STAT: nxt_rdata[9:0] = cur_len_ff;
      default: nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign wv = be_merge(32'h0, avs_writedata, avs_byteenable);

  // ==========================================
  // control registers
  cswd_dev_mode_t prev_mode_ff;
  logic fs_entry;
  logic silence_exp;
  logic [31:0] tim_m;
  logic [31:0] lim_m;
  // merged views keep the unwritten byte lanes of each register
  assign tim_m = be_merge({18'h0, sp_ff, tq_ff}, wv, avs_byteenable);
  assign lim_m = be_merge({6'h0, lim_hi_ff, 6'h0, lim_lo_ff}, wv, avs_byteenable);
  assign fs_entry = (dev_mode == CSWD_DEV_FAILSAFE) && (prev_mode_ff != CSWD_DEV_FAILSAFE);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_mode_ff <= CSWD_DEV_NORMAL;
      trx_mode_ff <= `CSWD_MODE_OFF;
    end else begin
      prev_mode_ff <= dev_mode;
      if (fs_entry) begin
        trx_mode_ff <= `CSWD_MODE_WAKE; // R1
      end else if (wr_go && avs_address == `CSWD_ADR_MODE && avs_byteenable[0]) begin
        trx_mode_ff <= avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tq_ff <= `CSWD_TQ_RST;
      sp_ff <= `CSWD_SP_RST; // R22
      rcv_en_ff <= 1'b0;
      osc_sel_ff <= 2'h0;
      rx_sel_ff <= 1'b0;
      lim_lo_ff <= `CSWD_LIM_LO_RST;
      lim_hi_ff <= `CSWD_LIM_HI_RST;
    end else if (wr_go) begin
      case (avs_address)
        `CSWD_ADR_TIMING: begin
          tq_ff <= tim_m[7:0]; // R4
          sp_ff <= tim_m[13:8];
        end
        `CSWD_ADR_RCV_CTRL: begin
          if (avs_byteenable[0]) begin
            {rx_sel_ff, osc_sel_ff, rcv_en_ff} <= avs_writedata[3:0]; // R5
          end
        end
        `CSWD_ADR_RCV_LIM: begin
          lim_lo_ff <= lim_m[9:0];
          lim_hi_ff <= lim_m[25:16];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fd_en_ff <= 1'b0;
      error_count_field_dis_ff <= 1'b0;
      flt_ff <= `CSWD_FLT_RST;
    end else begin
      if (wr_go && avs_address == `CSWD_ADR_FAST && avs_byteenable[0]) begin
        fd_en_ff <= avs_writedata[0]; // R8
        flt_ff <= avs_writedata[5:2]; // R12
      end
      // hardware clear wins here: a silence expiry always drops the bit
      if (silence_exp) begin
        error_count_field_dis_ff <= 1'b0; // R16
      end else if (wr_go && avs_address == `CSWD_ADR_FAST && avs_byteenable[0]) begin
        error_count_field_dis_ff <= avs_writedata[1];
      end
    end
  end

  // ==========================================
  // oscillator calibration and trim
  logic txd_q_ff;
  logic trim_ok;
  assign trim_ok = cal_ff && (trim_en_ff == 2'h3);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_ff <= 1'b0;
      trim_en_ff <= 2'h0;
      trim_ff <= `CSWD_TRIM_RST;
    end else if (wr_go) begin
      if (avs_address == `CSWD_ADR_CAL && avs_byteenable[0]) begin
        {trim_en_ff, cal_ff} <= avs_writedata[2:0];
      end
      if (avs_address == `CSWD_ADR_TRIM && avs_byteenable[0] && trim_ok) begin
        trim_ff <= avs_writedata[7:0]; // R7
      end
    end
  end
  assign osc_trim_out = trim_ff;

  // pulse is the low phase of the transmit pin; counter saturates, no wrap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txd_q_ff <= 1'b1;
      cal_cnt_ff <= 16'h0;
      cal_res_ff <= 16'h0;
    end else begin
      txd_q_ff <= bus_transmit_pin;
      if (cal_ff && trx_mode_ff == `CSWD_MODE_OFF) begin
        if (txd_q_ff && !bus_transmit_pin) begin
          cal_cnt_ff <= 16'h1; // R6
        end else if (!bus_transmit_pin && cal_cnt_ff != 16'hFFFF) begin
          cal_cnt_ff <= cal_cnt_ff + 16'h1;
        end else if (!txd_q_ff && bus_transmit_pin) begin
          cal_res_ff <= cal_cnt_ff; // R6
        end
      end
    end
  end

  // ==========================================
  // bus sampling, silence timer, clock recovery
  logic rx_bit;
  logic rx_q_ff;
  logic fall;
  logic [31:0] sil_ff;
  logic [9:0] nom_len;
  logic [9:0] edge_cnt_ff;
  assign rx_bit = rx_sel_ff ? rx_normal : rx_low_power; // R5
  assign fall = rx_q_ff && !rx_bit;
  // operands widened first so the product cannot wrap at eight bits
  assign nom_len = {2'h0, tq_ff} * (10'(osc_sel_ff) + 10'h1); // R4

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q_ff <= 1'b1;
      sil_ff <= 32'h0;
      silence_exp <= 1'b0;
    end else begin
      rx_q_ff <= rx_bit;
      silence_exp <= (sil_ff == 32'(SILENCE_CYC - 1)) && rx_bit;
      sil_ff <= !rx_bit ? 32'h0 : (sil_ff == 32'(SILENCE_CYC) ? sil_ff : sil_ff + 32'h1);
    end
  end

  // only single-bit edge spacings are used; longer runs carry no phase info
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_cnt_ff <= 10'h0;
      cur_len_ff <= 10'(`CSWD_TQ_RST);
    end else begin
      edge_cnt_ff <= fall ? 10'h1 : (edge_cnt_ff == 10'h3FF ? edge_cnt_ff : edge_cnt_ff + 10'h1);
      if (!rcv_en_ff) begin
        cur_len_ff <= nom_len; // R17
      end else if (cur_len_ff <= lim_lo_ff || cur_len_ff >= lim_hi_ff) begin
        cur_len_ff <= nom_len; // R18
      end else if (fall && edge_cnt_ff > {1'b0, cur_len_ff[9:1]}
                   && edge_cnt_ff < cur_len_ff + {1'b0, cur_len_ff[9:1]}) begin
        if (edge_cnt_ff > cur_len_ff) begin
          cur_len_ff <= cur_len_ff + 10'h1; // R17
        end else if (edge_cnt_ff < cur_len_ff) begin
          cur_len_ff <= cur_len_ff - 10'h1;
        end
      end
    end
  end

  // ==========================================
  // frame decoder
  cswd_dec_st_t st_ff;
  logic [9:0] bcnt_ff;
  logic [9:0] samp_at;
  logic smp;
  logic [2:0] same_ff;
  logic last_ff;
  logic [4:0] idx_ff;
  logic [2:0] rec_ff;
  logic [3:0] dom_ff;
  logic bad_ff;
  logic ev_ok;
  logic ev_fd;
  logic ev_bad;
  logic sel_act;
  assign samp_at = 10'(({6'h0, cur_len_ff} * {10'h0, sp_ff}) >> 6);
  assign smp = (bcnt_ff == samp_at);
  assign sel_act = trx_mode_ff[2] && (trx_mode_ff != `CSWD_MODE_SEL_OFF) && !wake_flags_ff[3]; // R23

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_ff <= 10'h0;
      dom_ff <= 4'h0;
    end else begin
      bcnt_ff <= (fall && st_ff == CSWD_ST_IDLE) || bcnt_ff >= cur_len_ff - 10'h1 ? 10'h0 : bcnt_ff + 10'h1;
      dom_ff <= rx_bit ? 4'h0 : (dom_ff == 4'hF ? dom_ff : dom_ff + 4'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= CSWD_ST_WAIT;
      same_ff <= 3'h0;
      last_ff <= 1'b1;
      idx_ff <= 5'h0;
      rec_ff <= 3'h0;
      bad_ff <= 1'b0;
      ev_ok <= 1'b0;
      ev_fd <= 1'b0;
      ev_bad <= 1'b0;
    end else begin
      ev_ok <= 1'b0;
      ev_fd <= 1'b0;
      ev_bad <= 1'b0;
      if (smp) begin
        rec_ff <= rx_bit ? (rec_ff == `CSWD_EOF_BITS ? rec_ff : rec_ff + 3'h1) : 3'h0;
        case (st_ff)
          CSWD_ST_IDLE: begin
            if (!rx_bit) begin
              st_ff <= CSWD_ST_RUN;
              idx_ff <= 5'h1;
              same_ff <= 3'h1;
              last_ff <= 1'b0;
            end
          end
          CSWD_ST_RUN: begin
            same_ff <= (rx_bit == last_ff) ? same_ff + 3'h1 : 3'h1;
            last_ff <= rx_bit;
            if (rx_bit && rec_ff == `CSWD_EOF_BITS - 3'h1) begin
              ev_ok <= 1'b1;
              st_ff <= CSWD_ST_IDLE;
            end else if (same_ff == 3'h5 && rx_bit == last_ff && !rx_bit) begin
              ev_bad <= 1'b1;
              st_ff <= CSWD_ST_WAIT;
            end else if (!(same_ff == 3'h5 && rx_bit != last_ff)) begin
              idx_ff <= idx_ff == 5'h1F ? idx_ff : idx_ff + 5'h1;
              if (idx_ff == `CSWD_EDL_IDX && rx_bit) begin
                if (fd_en_ff) begin
                  st_ff <= CSWD_ST_SKIP; // R10
                end else begin
                  ev_fd <= 1'b1;
                  st_ff <= CSWD_ST_WAIT;
                end
              end
            end
          end
          CSWD_ST_SKIP: begin
            // no stuff, crc or form checks here; only the end of frame counts
            if (rx_bit && dom_ff < flt_ff && rec_ff == `CSWD_EOF_BITS - 3'h1) begin
              ev_fd <= 1'b1; // R9
              st_ff <= CSWD_ST_IDLE; // R11
            end
          end
          CSWD_ST_WAIT: begin
            if (rx_bit && rec_ff == `CSWD_EOF_BITS - 3'h1) begin
              st_ff <= CSWD_ST_IDLE;
            end
          end
          default: st_ff <= CSWD_ST_WAIT;
        endcase
      end
      // dominant runs reaching the filter reset the skipper; shorter fast data bits only when one is sampled
      if (st_ff == CSWD_ST_SKIP && dom_ff == flt_ff) begin
        rec_ff <= 3'h0; // R12
      end
    end
  end

  // ==========================================
  // error counter and wake flags
  logic ev_wuf;
  logic ev_ovf;
  logic [4:0] clr;
  assign ev_wuf = ev_ok && sel_act && frame_match_in; // R9
  assign ev_ovf = sel_act && (error_count_field_ff == `CSWD_ERROR_COUNT_FIELD_OVF - 6'h1) && (ev_bad || (ev_fd && !fd_en_ff));
  assign clr = (wr_go && avs_address == `CSWD_ADR_WAKE && avs_byteenable[0]) ? avs_writedata[4:0] : 5'h0;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      error_count_field_ff <= 6'h0;
    end else if (fd_en_ff && error_count_field_dis_ff) begin
      error_count_field_ff <= 6'h0; // R15
    end else if (error_count_field_ff == `CSWD_ERROR_COUNT_FIELD_OVF) begin
      error_count_field_ff <= (clr[3]) ? 6'h0 : error_count_field_ff;
    end else if (ev_bad || (ev_fd && !fd_en_ff)) begin
      error_count_field_ff <= error_count_field_ff + 6'h1; // R13
    end else if ((ev_ok || (ev_fd && fd_en_ff)) && error_count_field_ff != 6'h0) begin
      error_count_field_ff <= error_count_field_ff - 6'h1; // R14
    end
  end

  // bits: 0 bus wake, 1 pattern, 2 frame, 3 system error, 4 spare; set beats clear
  logic [4:0] set_v;
  assign set_v = {1'b0, ev_ovf, ev_wuf, pattern_wake_in && trx_mode_ff != `CSWD_MODE_OFF, 1'b0};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_flags_ff <= 5'h0;
    end else begin
      wake_flags_ff[4:1] <= set_v[4:1] | (wake_flags_ff[4:1] & ~clr[4:1]); // R3
      wake_flags_ff[0] <= (|set_v) | (wake_flags_ff[0] & ~clr[0]); // R3
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_restart <= 1'b0;
      wake_irq <= 1'b0;
      trx_mode_out <= `CSWD_MODE_OFF;
      selective_wake_out <= 1'b0;
    end else begin
      wake_restart <= (|set_v) && dev_mode == CSWD_DEV_SLEEP; // R2
      wake_irq <= (|set_v) && (dev_mode == CSWD_DEV_NORMAL || dev_mode == CSWD_DEV_STOP); // R2
      trx_mode_out <= trx_mode_ff;
      selective_wake_out <= sel_act && dev_mode != CSWD_DEV_FAILSAFE; // R1
    end
  end

  // ==========================================
  // checks
  sequence s_fs_entry;
    dev_mode == CSWD_DEV_FAILSAFE && $past(dev_mode) != CSWD_DEV_FAILSAFE;
  endsequence
  AST_FAILSAFE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
    s_fs_entry |=> trx_mode_ff == `CSWD_MODE_WAKE ##1 !selective_wake_out) else $error("failsafe mode wrong");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!arst_n) // R2
    (|set_v) && dev_mode == CSWD_DEV_SLEEP |=> wake_restart && !wake_irq) else $error("no restart");
  AST_FLAG: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
    ev_wuf |=> wake_flags_ff[0] && wake_flags_ff[2]) else $error("wake flags not set");
  AST_TRIM: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
    !trim_ok |=> $stable(trim_ff)) else $error("trim changed while locked");
  AST_NO_FD_WAKE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R9
    st_ff == CSWD_ST_SKIP |-> !ev_wuf) else $error("wake from fast frame");
  AST_HOLD0: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
    fd_en_ff && error_count_field_dis_ff |=> error_count_field_ff == 6'h0) else $error("counter not held");
  AST_SIL: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
    silence_exp |=> !error_count_field_dis_ff) else $error("disable not cleared");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (!arst_n) // R18
    rcv_en_ff && cur_len_ff >= lim_hi_ff |=> cur_len_ff == $past(nom_len)) else $error("no reload");
  AST_SYSTEM_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (!arst_n) // R23
    wake_flags_ff[3] |-> !ev_wuf) else $error("frame wake during system error");
endmodule // cswd_top

// [rtl/cswd_regs.svh]
`ifndef CSWD_REGS_SVH
`define CSWD_REGS_SVH
// Behaviour
// R1: entering fail-safe forces plain wake-capable mode, selective wake off.
// R2: bus wake restarts a sleeping device, interrupts in normal or stop.
// R3: bus wake sets wake flag; cause shown in pattern, frame, error, count.
// R4: bit timing sets quanta per bit and sample point, scaled by clock select.
// R5: receiver select picks which bus receiver feeds the decoder.
// R6: with calibrate set and transceiver off, pulse length is counted, readable.
// R7: trim writes accepted only with trim enables 11 and calibrate set.
// R8: tolerant decoding is on when its enable bit is written 1.
// R9: tolerant mode skips fast frames: no checks, never a wake.
// R10: tolerant mode stops on extended length bit 1, continues on 0.
// R11: after a skipped fast frame, ready again once end of frame seen.
// R12: tolerant mode accepts dominant only after filter-set minimum duration; the skipper also takes any dominant level seen at a sample point.
// R13: tolerant off: count up on fast or bad frames, down on good.
// R14: tolerant on, disable 0: up on bad, down on any good frame.
// R15: tolerant on and disable 1: error counter held at zero.
// R16: counter-disable bit clears itself when the silence timer expires.
// R17: recovery enabled adjusts decoding bit length; disabled, no adjustment.
// R18: recovery at its limits discards measurements, reloads bit timing.
// R19: host enables recovery in order: off, clock, timing, then enable.
// R20: host toggles recovery only with transceiver off.
// R21: host updates clock select, timing and limits on baud change.
// R22: sample point resets to 11 0011, about eighty percent.
// R23: while system error is set, frame wake detection is inactive.
// R24: selective mode code is 101 and stays readable after frame wake.
`define CSWD_ADR_MODE 4'h0
`define CSWD_ADR_WAKE 4'h1
`define CSWD_ADR_TIMING 4'h2
`define CSWD_ADR_RCV_CTRL 4'h3
`define CSWD_ADR_RCV_LIM 4'h4
`define CSWD_ADR_FAST 4'h5
`define CSWD_ADR_CAL 4'h6
`define CSWD_ADR_CAL_HI 4'h7
`define CSWD_ADR_CAL_LO 4'h8
`define CSWD_ADR_TRIM 4'h9
`define CSWD_ADR_RCV_STAT 4'hA
`define CSWD_MODE_OFF 3'h0
`define CSWD_MODE_WAKE 3'h1
`define CSWD_MODE_SEL_OFF 3'h4
`define CSWD_MODE_SELECTIVE 3'h5
`define CSWD_TQ_RST 8'h10
`define CSWD_SP_RST 6'h33
`define CSWD_LIM_LO_RST 10'h008
`define CSWD_LIM_HI_RST 10'h100
`define CSWD_TRIM_RST 8'h80
`define CSWD_FLT_RST 4'h4
`define CSWD_ERROR_COUNT_FIELD_OVF 6'h20
`define CSWD_EOF_BITS 3'h7
`define CSWD_EDL_IDX 5'h0E
`define CSWD_SILENCE_US 1000
`define CSWD_CLK_MHZ 125
`define CSWD_SILENCE_CYC (`CSWD_SILENCE_US * `CSWD_CLK_MHZ)
`endif

// [rtl/cswd_pkg.sv]
package cswd_pkg;
  typedef enum logic [1:0] {
    CSWD_DEV_NORMAL,
    CSWD_DEV_STOP,
    CSWD_DEV_SLEEP,
    CSWD_DEV_FAILSAFE
  } cswd_dev_mode_t;
  typedef enum logic [1:0] {
    CSWD_ST_IDLE,
    CSWD_ST_RUN,
    CSWD_ST_SKIP,
    CSWD_ST_WAIT
  } cswd_dec_st_t;
endpackage

// [test/cswd_can_node.sv]
`timescale 1ns/1ns
// ============================================================
// other node on the bus: drives one receiver line, the other stays recessive
module cswd_can_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk,
  output logic line_normal,
  output logic line_low_power
);
  // idle bus is recessive, as the bus bias pulls it there
  initial begin
    line_normal = 1'b1;
    line_low_power = 1'b1;
  end
  task automatic put_bit(input logic b, input logic low);
    repeat (BIT_CYC) begin
      @(posedge ref_clk);
      if (low) begin
        line_low_power <= b;
      end else begin
        line_normal <= b;
      end
    end
  endtask
  // bad adds six dominant bits; only used on classic frames
  task automatic send(input logic fast, input logic bad, input logic low);
    put_bit(1'b0, low);
    for (int i = 1; i < 13; i++) put_bit(i[0], low);
    // three copies so the length bit lands on either count from the start bit
    repeat (3) put_bit(fast, low);
    if (bad) repeat (6) put_bit(1'b0, low);
    for (int i = 0; i < 6; i++) put_bit(i[0], low);
    repeat (10) put_bit(1'b1, low);
  endtask
endmodule // cswd_can_node

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "cswd_regs.svh"
module tb_top;
  import cswd_pkg::*;
  typedef struct {string name; logic [31:0] val;} cswd_exp_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  cswd_dev_mode_t dev_mode = CSWD_DEV_NORMAL;
  logic bus_transmit_pin = 1'b1;
  logic pattern_wake_in = 1'b0;
  logic frame_match_in = 1'b0;
  logic rx_normal;
  logic rx_low_power;
  logic [2:0] trx_mode_out;
  logic selective_wake_out;
  logic wake_restart;
  logic wake_irq;
  logic [7:0] osc_trim_out;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 12;
  logic [7:0] t1;
  logic [7:0] t2;
  cswd_exp_t e;
  cswd_exp_t exp_q[$];
  logic [1:0] wake_q[$];
  always #4 ref_clk = ~ref_clk;
  cswd_top #(.SILENCE_CYC(200)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_mode(dev_mode),
    .rx_normal(rx_normal), .rx_low_power(rx_low_power), .bus_transmit_pin(bus_transmit_pin),
    .pattern_wake_in(pattern_wake_in), .frame_match_in(frame_match_in), .trx_mode_out(trx_mode_out),
    .selective_wake_out(selective_wake_out), .wake_restart(wake_restart), .wake_irq(wake_irq),
    .osc_trim_out(osc_trim_out)
  );
  cswd_can_node #(.BIT_CYC(16)) node (
    .ref_clk(ref_clk),
    .line_normal(rx_normal),
    .line_low_power(rx_low_power)
  );
  // ============================================================
  // checks and bus cycles
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v, input string n);
    exp_q.push_back('{n, v});
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask
  task automatic frm(input logic fast, input logic bad, input logic low, input logic [5:0] cnt);
    node.send(fast, bad, low);
    repeat (2) @(posedge ref_clk);
    rd(`CSWD_ADR_WAKE, {21'h0, cnt, 5'h0}, "error_count_field");
  endtask
  task automatic stop_test;
    if (wake_q.size() != 0) begin
      error_cnt++;
      $display("ERROR wake expected %0d more pulses seen 0", wake_q.size());
    end
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ============================================================
  // result watcher: oldest note is compared when an answer appears
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("ERROR readdata expected none seen %h", avs_readdata);
      end else begin
        e = exp_q.pop_front();
        chk(e.name, e.val, avs_readdata);
      end
    end
    if ((wake_restart | wake_irq) === 1'b1) begin
      if (wake_q.size() == 0) begin
        error_cnt++;
        $display("ERROR wake expected none seen %b", {wake_restart, wake_irq});
      end else begin
        chk("wake", {30'h0, wake_q.pop_front()}, {30'h0, wake_restart, wake_irq});
      end
    end
  end
  // the whole sequence needs well under 10000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("ERROR timeout expected finish seen hang");
      stop_test;
    end
  end
  // ============================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`CSWD_ADR_TIMING, {18'h0, `CSWD_SP_RST, `CSWD_TQ_RST}, "bit_timing_ctrl");
    rd(`CSWD_ADR_RCV_LIM, {6'h0, `CSWD_LIM_HI_RST, 6'h0, `CSWD_LIM_LO_RST}, "recovery_limits");
    rd(`CSWD_ADR_FAST, {26'h0, `CSWD_FLT_RST, 2'h0}, "fast_frame_ctrl");
    rd(`CSWD_ADR_RCV_STAT, {24'h0, `CSWD_TQ_RST}, "bit_length");
    wr(4'hB, 32'hFFFF_FFFF);
    rd(4'hB, 32'h0, "unmapped");
    $display("test reset_map done");
    // recovery settings changed with the transceiver off only
    wr(`CSWD_ADR_MODE, {29'h0, `CSWD_MODE_OFF});
    wr(`CSWD_ADR_RCV_CTRL, 32'hA);
    rd(`CSWD_ADR_RCV_STAT, {23'h0, `CSWD_TQ_RST, 1'b0}, "bit_length");
    wr(`CSWD_ADR_RCV_CTRL, 32'h8);
    $display("test bit_timing done");
    wr(`CSWD_ADR_CAL, 32'h1);
    @(posedge ref_clk);
    bus_transmit_pin <= 1'b0;
    repeat (300) @(posedge ref_clk);
    bus_transmit_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`CSWD_ADR_CAL_HI, 32'h1, "calibration_count_high");
    rd(`CSWD_ADR_CAL_LO, 32'h2C, "calibration_count_low");
    t1 = $random(seed);
    t2 = $random(seed);
    wr(`CSWD_ADR_TRIM, {24'h0, t1});
    rd(`CSWD_ADR_TRIM, {24'h0, `CSWD_TRIM_RST}, "oscillator_trim_value");
    wr(`CSWD_ADR_CAL, 32'h7);
    wr(`CSWD_ADR_TRIM, {24'h0, t2});
    rd(`CSWD_ADR_TRIM, {24'h0, t2}, "oscillator_trim_value");
    wr(`CSWD_ADR_CAL, 32'h0);
    wr(`CSWD_ADR_TRIM, {24'h0, ~t2});
    @(posedge ref_clk);
    chk("osc_trim_out", {24'h0, t2}, {24'h0, osc_trim_out});
    $display("test calibrate_trim done");
    wr(`CSWD_ADR_MODE, {29'h0, `CSWD_MODE_WAKE});
    for (int m = 0; m < 3; m++) begin
      dev_mode <= (m == 0) ? CSWD_DEV_SLEEP : (m == 1) ? CSWD_DEV_NORMAL : CSWD_DEV_STOP;
      wake_q.push_back((m == 0) ? 2'b10 : 2'b01);
      @(posedge ref_clk);
      pattern_wake_in <= 1'b1;
      @(posedge ref_clk);
      pattern_wake_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    rd(`CSWD_ADR_WAKE, 32'h3, "bus_wake_flag");
    wr(`CSWD_ADR_WAKE, 32'h3);
    rd(`CSWD_ADR_WAKE, 32'h0, "bus_wake_flag");
    $display("test pattern_wake done");
    dev_mode <= CSWD_DEV_NORMAL;
    wr(`CSWD_ADR_MODE, {29'h0, `CSWD_MODE_SELECTIVE});
    rd(`CSWD_ADR_MODE, {29'h0, `CSWD_MODE_SELECTIVE}, "mode");
    chk("trx_mode_out", {29'h0, `CSWD_MODE_SELECTIVE}, {29'h0, trx_mode_out});
    chk("selective_wake_out", 32'h1, {31'h0, selective_wake_out});
    // matching classic frame wakes; later fast frames with the match held must not
    frame_match_in <= 1'b1;
    wake_q.push_back(2'b01);
    node.send(1'b0, 1'b0, 1'b0);
    rd(`CSWD_ADR_WAKE, 32'h5, "frame_wake_flag");
    wr(`CSWD_ADR_WAKE, 32'h5);
    frm(1'b0, 1'b1, 1'b0, 6'd1);
    frm(1'b1, 1'b0, 1'b0, 6'd2);
    frm(1'b0, 1'b1, 1'b1, 6'd2);
    wr(`CSWD_ADR_FAST, 32'h11);
    frm(1'b1, 1'b0, 1'b0, 6'd1);
    frm(1'b0, 1'b1, 1'b0, 6'd2);
    wr(`CSWD_ADR_FAST, 32'h13);
    rd(`CSWD_ADR_FAST, 32'h13, "fast_frame_ctrl");
    frm(1'b0, 1'b1, 1'b0, 6'd0);
    repeat (250) @(posedge ref_clk);
    rd(`CSWD_ADR_FAST, 32'h11, "error_counter_disable");
    $display("test error_counter done");
    dev_mode <= CSWD_DEV_FAILSAFE;
    repeat (3) @(posedge ref_clk);
    chk("selective_wake_out", 32'h0, {31'h0, selective_wake_out});
    chk("trx_mode_out", {29'h0, `CSWD_MODE_WAKE}, {29'h0, trx_mode_out});
    $display("test fail_safe done");
    stop_test;
  end
endmodule // tb_top
